//--- logic/step_sequencer.v
// step sequencer: sixteen sections of signed speed and running time, played in order
// assumes core_clk at 100 MHz, synchronous srst, an avalon-mm master and a power_fail pin
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "step_sequencer_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// R1: mode 0 stops the drive after one full pass of all sections.
// R2: after a mode 0 stop, only a new run command restarts the sequence.
// R3: mode 1 completes one pass, then holds last section's speed and direction.
// R4: mode 2 restarts at section 0 after each completed pass.
// R5: cyclic mode repeats until a stop command, then stops the drive.
// R6: retention 1 saves stage and frequency at power loss and resumes there.
// R7: section speed is signed -100.0..100.0 percent, 100 percent means max frequency.
// R8: section time is 0.0..6553.5 in 0.1 steps, seconds or minutes by selector.
// R9: negative section speed commands reverse, positive commands forward.
// R10: sixteen speed and time pairs, sections 0 to 15, drive the sequence.
// R11: after reset every section speed and time reads 0.0.
// R12: advance when elapsed section time reaches the section's running time.
// R13: a tick of one tenth of the time unit counts section running time.
module step_sequencer #(
  parameter SECTIONS = 16,
  parameter TENTH_SEC_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // power loss warning pin
  input wire power_fail,
  // drive command outputs
  output reg drive_run,
  output reg drive_reverse,
  output reg [15:0] drive_freq_ref
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  localparam [3:0] CTRL_RST_V = `CTRL_RST;

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, so every access completes on the second edge
  reg ack_r;
  wire bus_req = avs_read | avs_write;
  wire bus_go = bus_req & ack_r;
  assign avs_waitrequest = bus_req & ~ack_r;

  always @(posedge core_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  wire wr_go = bus_go & avs_write;
  wire sect_hit = (avs_address >= `SEQ_SECT_BASE) && (avs_address <= `SEQ_SECT_LAST);
  wire [7:0] sect_ofs = avs_address - `SEQ_SECT_BASE;
  wire [3:0] sect_idx = sect_ofs[6:3];
  wire sect_is_time = sect_ofs[2];

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  reg [1:0] mode_r;
  reg retain_en_r;
  reg unit_min_r;
  reg [15:0] max_freq_r;

  always @(posedge core_clk) begin
    if (srst) begin
      mode_r <= CTRL_RST_V[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      retain_en_r <= CTRL_RST_V[`CTRL_RETAIN_BIT];
      unit_min_r <= CTRL_RST_V[`CTRL_UNIT_BIT];
      max_freq_r <= `MAXF_RST;
    end else if (wr_go && avs_byteenable[0]) begin
      if (avs_address == `SEQ_CTRL_OFS) begin
        mode_r <= avs_writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        retain_en_r <= avs_writedata[`CTRL_RETAIN_BIT];
        unit_min_r <= avs_writedata[`CTRL_UNIT_BIT];
      end
      if (avs_address == `SEQ_MAXF_OFS && avs_byteenable[1]) begin
        max_freq_r <= avs_writedata[15:0];
      end
    end
  end

  wire cmd_hit = wr_go && avs_byteenable[0] && (avs_address == `SEQ_CMD_OFS);
  wire run_cmd = cmd_hit & avs_writedata[`CMD_RUN_BIT];
  wire stop_cmd = cmd_hit & avs_writedata[`CMD_STOP_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // section table: one speed and one time word per section
  reg signed [15:0] speed_mem [0:SECTIONS-1];
  reg [15:0] time_mem [0:SECTIONS-1];

  // out-of-range speeds saturate, so the scaled reference never passes max
  wire signed [15:0] wr_speed = avs_writedata[15:0];
  wire signed [15:0] clamp_speed = (wr_speed > `SPEED_MAX) ? `SPEED_MAX :
                                   (wr_speed < `SPEED_MIN) ? `SPEED_MIN : wr_speed;

  genvar gi;
  generate
    for (gi = 0; gi < SECTIONS; gi = gi + 1) begin : g_sect
      wire hit = wr_go && sect_hit && (sect_idx == gi) && (&avs_byteenable[1:0]);
      always @(posedge core_clk) begin
        if (srst) begin
          speed_mem[gi] <= `SECT_SPEED_RST; // [R11]
          time_mem[gi] <= `SECT_TIME_RST; // [R11]
        end else if (hit && !sect_is_time) begin
          speed_mem[gi] <= clamp_speed; // [R7]
        end else if (hit && sect_is_time) begin
          time_mem[gi] <= avs_writedata[15:0]; // [R8]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // power-fail pin: three flops, a change counts when the last two agree
  reg [2:0] pf_sync_r;
  reg pf_level_r;

  always @(posedge core_clk) begin
    if (srst) begin
      pf_sync_r <= 3'h0;
      pf_level_r <= 1'b0;
    end else begin
      pf_sync_r <= {pf_sync_r[1:0], power_fail};
      if (pf_sync_r[2] == pf_sync_r[1]) begin
        pf_level_r <= pf_sync_r[2];
      end
    end
  end

  reg pf_prev_r;
  always @(posedge core_clk) begin
    if (srst) begin
      pf_prev_r <= 1'b0;
    end else begin
      pf_prev_r <= pf_level_r;
    end
  end
  wire pf_event = pf_level_r & ~pf_prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // time base: tenth-second prescaler, then x60 when minutes are selected
  reg [31:0] pre_cnt_r;
  reg [5:0] min_cnt_r;
  reg [1:0] state_r;
  wire counting = (state_r == ST_RUN);
  wire running = (state_r != ST_IDLE);
  localparam [31:0] TENTH_LAST = TENTH_SEC_CYCLES - 1;
  wire tenth_sec = (pre_cnt_r == TENTH_LAST);
  wire unit_tick = tenth_sec && (!unit_min_r || min_cnt_r == `MIN_PER_SEC - 6'h01);

  // prescaler restarts whenever the sequencer leaves run, so each start is aligned
  always @(posedge core_clk) begin
    if (srst || !counting) begin
      pre_cnt_r <= 32'h0000_0000;
      min_cnt_r <= 6'h00;
    end else if (tenth_sec) begin
      pre_cnt_r <= 32'h0000_0000;
      min_cnt_r <= unit_tick ? 6'h00 : min_cnt_r + 6'h01; // [R13]
    end else begin
      pre_cnt_r <= pre_cnt_r + 32'h0000_0001; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  reg [3:0] stage_r;
  reg [15:0] elapsed_r;
  reg done_r;
  reg saved_r;
  reg [3:0] saved_stage_r;
  reg signed [15:0] saved_speed_r;
  reg resume_r;
  reg [1:0] state_nxt;
  reg [3:0] stage_nxt;
  reg [15:0] elapsed_nxt;
  reg done_nxt;

  wire last_stage = (stage_r == SECTIONS - 1);
  wire sect_end = (elapsed_r >= time_mem[stage_r]); // [R12]
  // stop and power loss outrank run when they land in the same cycle
  wire start_go = run_cmd && !stop_cmd && !pf_event && (state_r == ST_IDLE);
  wire resume_go = retain_en_r && saved_r;

  always @* begin
    state_nxt = state_r;
    stage_nxt = stage_r;
    elapsed_nxt = elapsed_r;
    done_nxt = done_r;
    case (state_r)
      ST_IDLE: begin
        if (start_go) begin
          state_nxt = ST_RUN; // [R2]
          done_nxt = 1'b0;
          elapsed_nxt = 16'h0000;
          stage_nxt = resume_go ? saved_stage_r : 4'h0; // [R6]
        end
      end
      ST_RUN: begin
        if (stop_cmd) begin
          state_nxt = ST_IDLE; // [R5]
        end else if (pf_event) begin
          state_nxt = ST_IDLE; // [R6]
        end else if (sect_end) begin
          elapsed_nxt = 16'h0000;
          if (!last_stage) begin
            stage_nxt = stage_r + 4'h1; // [R10] [R12]
          end else begin
            case (mode_r)
              `MODE_CYCLE: begin
                stage_nxt = 4'h0; // [R4]
              end
              `MODE_HOLD: begin
                state_nxt = ST_HOLD; // [R3]
              end
              default: begin
                // mode 3 is treated as a single pass
                state_nxt = ST_IDLE; // [R1]
                done_nxt = 1'b1;
              end
            endcase
          end
        end else if (unit_tick) begin
          elapsed_nxt = elapsed_r + 16'h0001; // [R12]
        end
      end
      ST_HOLD: begin
        // holding keeps the last section's output until stop or power loss
        if (stop_cmd || pf_event) begin
          state_nxt = ST_IDLE; // [R5]
        end
      end
      default: begin
        // unused state code falls back to idle
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      stage_r <= 4'h0;
      elapsed_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stage_r <= stage_nxt;
      elapsed_r <= elapsed_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // retention: stage and speed captured on power loss, used once on next run
  wire signed [15:0] cur_speed = speed_mem[stage_r];

  always @(posedge core_clk) begin
    if (srst) begin
      saved_r <= 1'b0;
      saved_stage_r <= 4'h0;
      saved_speed_r <= 16'sh0000;
      resume_r <= 1'b0;
    end else begin
      if (pf_event && state_r != ST_IDLE && retain_en_r) begin
        saved_r <= 1'b1; // [R6]
        saved_stage_r <= stage_r;
        saved_speed_r <= cur_speed;
      end else if (start_go) begin
        saved_r <= 1'b0;
        resume_r <= resume_go;
      end else if (state_r == ST_RUN && sect_end) begin
        resume_r <= 1'b0;
      end
      if (!retain_en_r && !(pf_event && state_r != ST_IDLE)) begin
        saved_r <= 1'b0; // [R6]
      end
    end
  end

  // resumed section keeps its saved speed, scaled by the current max_freq_r, until it ends
  wire signed [15:0] act_speed = resume_r ? saved_speed_r : cur_speed;
  wire [15:0] speed_mag = act_speed[15] ? (16'h0000 - act_speed) : act_speed;
  wire [33:0] prod = {18'h0_0000, speed_mag} * {18'h0_0000, max_freq_r};
  wire [33:0] scaled = prod / `SPEED_FULL; // [R7]

  always @(posedge core_clk) begin
    if (srst) begin
      drive_run <= 1'b0;
      drive_reverse <= 1'b0;
      drive_freq_ref <= 16'h0000;
    end else begin
      drive_run <= running;
      // gated so a negative last section cannot leave reverse set while stopped
      drive_reverse <= running & act_speed[15]; // [R9]
      drive_freq_ref <= running ? scaled[15:0] : 16'h0000; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, captured in the wait cycle so data stand at the completing edge
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (sect_hit) begin
      rd_nxt = sect_is_time ? {16'h0000, time_mem[sect_idx]} :
                              {{16{speed_mem[sect_idx][15]}}, speed_mem[sect_idx]};
    end else begin
      case (avs_address)
        `SEQ_CTRL_OFS: rd_nxt = {28'h000_0000, unit_min_r, retain_en_r, mode_r};
        `SEQ_MAXF_OFS: rd_nxt = {16'h0000, max_freq_r};
        `SEQ_STAT_OFS: rd_nxt = {20'h0_0000, stage_r, 3'h0, saved_r, drive_reverse,
                                 done_r, state_r == ST_HOLD, state_r != ST_IDLE};
        `SEQ_FREQ_OFS: rd_nxt = {16'h0000, drive_freq_ref};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_nxt;
    end
  end

endmodule
`default_nettype wire

//--- logic/step_sequencer_map.vh
// register offsets, field positions, reset values and timing for the step sequencer
// assumes byte addresses on a 32-bit avalon-mm slave, one word per register
`ifndef STEP_SEQUENCER_MAP_VH
`define STEP_SEQUENCER_MAP_VH

// register byte offsets
`define SEQ_CTRL_OFS 8'h00
`define SEQ_CMD_OFS 8'h04
`define SEQ_MAXF_OFS 8'h08
`define SEQ_STAT_OFS 8'h0C
`define SEQ_FREQ_OFS 8'h10
`define SEQ_SECT_BASE 8'h40
`define SEQ_SECT_LAST 8'hBC

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_RETAIN_BIT 2
`define CTRL_UNIT_BIT 3

// command register fields (write-only pulses)
`define CMD_RUN_BIT 0
`define CMD_STOP_BIT 1

// status register fields
`define STAT_RUN_BIT 0
`define STAT_HOLD_BIT 1
`define STAT_DONE_BIT 2
`define STAT_REV_BIT 3
`define STAT_SAVED_BIT 4
`define STAT_STAGE_LSB 8

// sequencer modes
`define MODE_ONCE 2'h0
`define MODE_HOLD 2'h1
`define MODE_CYCLE 2'h2

// reset values
`define CTRL_RST 4'h0
`define MAXF_RST 16'h1388
`define SECT_SPEED_RST 16'h0000
`define SECT_TIME_RST 16'h0000

// speed limits in 0.1 percent, and full scale
`define SPEED_MAX 16'sh03E8
`define SPEED_MIN -16'sh03E8
`define SPEED_FULL 34'sh0_0000_03E8

// timing: one tenth of a second, and tenths-of-minute multiplier
`define TICK_TIME_NS 100000000
`define CLK_PERIOD_NS 10
`define MIN_PER_SEC 6'h3C

`endif

//--- test/seq_checker_sva.sv
// checker: bus handshake and drive output relations of the step sequencer
// assumes binding into step_sequencer, seeing only its ports
`timescale 1ns/100ps
`default_nettype none
module seq_checker #(
  parameter TENTH_SEC_CYCLES = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // drive side
  input wire logic power_fail,
  input wire logic drive_run,
  input wire logic drive_reverse,
  input wire logic [15:0] drive_freq_ref
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire req = avs_read | avs_write;
  wire cmd_wr = avs_write & ~avs_waitrequest & (avs_address == 8'h04) & avs_byteenable[0];
  ////////////////////////////////////////////////////////////////////////////////
  wait_state_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait state");
  ack_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("ack late");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved");
  // run only counts from idle, so the antecedent requires drive_run low
  run_start_a: assert property (cmd_wr && avs_writedata[1:0] == 2'b01 && !drive_run
    |-> ##[2:4] drive_run)
    else $error("run not started");
  stop_cmd_a: assert property (cmd_wr && avs_writedata[1] |-> ##[1:4] !drive_run)
    else $error("stop ignored");
  pf_stop_a: assert property ($rose(power_fail) && drive_run |-> ##[1:8] !drive_run)
    else $error("power loss ignored");
  idle_freq_a: assert property (!drive_run |-> drive_freq_ref == 16'h0000)
    else $error("speed while idle");
  rev_run_a: assert property (drive_reverse |-> drive_run)
    else $error("reverse while idle");
  cover property ($rose(drive_run));
  cover property ($rose(power_fail) ##[1:8] $fell(drive_run));
  cover property (drive_reverse ##1 !drive_reverse && drive_run);
endmodule
bind step_sequencer seq_checker #(.TENTH_SEC_CYCLES(TENTH_SEC_CYCLES)) seq_checker_inst (
  .core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .power_fail, .drive_run, .drive_reverse, .drive_freq_ref);
`default_nettype wire

//--- test/drive_model.sv
// drive side model: supply monitor raising the power loss warning pin
// assumes the bench pulses pf_req for one cycle
`timescale 1ns/100ps
`default_nettype none
module drive_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bench request
  input wire logic pf_req,
  // warning pin
  output logic power_fail
);
  logic [2:0] hold_r = 3'h0;
  // held six cycles so the three-flop synchroniser sees a clean level
  always @(posedge core_clk) begin
    if (srst) hold_r <= 3'h0;
    else if (pf_req) hold_r <= 3'h6;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end
  assign power_fail = (hold_r != 3'h0);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// bench: programs sections over avalon-mm and watches the drive outputs
// assumes step_sequencer_map.vh on the include path; tick cut to 10 cycles
`timescale 1ns/100ps
`default_nettype none
`include "step_sequencer_map.vh"
module tb_top;
  logic core_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, pf_req = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, rd;
  logic [3:0] avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, power_fail, drive_run, drive_reverse;
  wire [15:0] drive_freq_ref;
  int n_mismatch = 0, n_tests = 0, durs[$];
  logic [16:0] vals[$];
  step_sequencer #(.SECTIONS(16), .TENTH_SEC_CYCLES(10)) step_sequencer_inst (.core_clk,
    .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .power_fail, .drive_run, .drive_reverse, .drive_freq_ref);
  drive_model drive_model_inst (.core_clk, .srst, .pf_req, .power_fail);
  initial forever #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] spd(input int n);
    spd = n[0] ? -(100 + 50 * n) : 100 + 50 * n;
  endfunction
  // default full scale 5000 makes each step exactly five units per 0.1 percent
  function automatic logic [16:0] ex(input int n);
    ex = {n[0], 16'((100 + 50 * n) * 5)};
  endfunction
  // log each distinct output step and how long it lasted
  always @(negedge core_clk) if (drive_run === 1'b1) begin
    if (vals.size() == 0 || vals[vals.size() - 1] !== {drive_reverse, drive_freq_ref}) begin
      vals.push_back({drive_reverse, drive_freq_ref});
      durs.push_back(0);
    end
    durs[durs.size() - 1] = durs[durs.size() - 1] + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task fail;
    n_mismatch++;
    complete_run();
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) fail();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_vals(input int k);
    int i;
    for (i = 0; i < 2000 && vals.size() < k; i++) @(posedge core_clk);
    if (vals.size() < k) fail();
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 50 && drive_run !== 1'b0; i++) @(negedge core_clk);
    if (drive_run !== 1'b0) fail();
  endtask
  task run_seq(input logic [31:0] ctrl);
    bus(1'b1, `SEQ_CTRL_OFS, ctrl);
    vals.delete();
    durs.delete();
    bus(1'b1, `SEQ_CMD_OFS, 32'h0000_0001);
  endtask
  task stop_check;
    bus(1'b1, `SEQ_CMD_OFS, 32'h0000_0002);
    repeat (3) @(negedge core_clk);
    check("drive_run after stop", drive_run, 32'h0000_0000);
  endtask
  task pf_case(input logic [31:0] ctrl, input int stage);
    run_seq(ctrl);
    wait_vals(3);
    pf_req <= 1'b1;
    @(posedge core_clk);
    pf_req <= 1'b0;
    wait_idle();
    bus(1'b0, `SEQ_STAT_OFS, 32'h0000_0000);
    check("saved flag", rd[4], ctrl[2]);
    run_seq(ctrl);
    wait_vals(1);
    check("resume step", vals[0], ex(stage));
    stop_check();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int n = 0; n < 32; n++) begin
      bus(1'b0, `SEQ_SECT_BASE + 8'(4 * n), 32'h0000_0000);
      check("section reset", rd, 32'h0000_0000);
    end
    bus(1'b0, `SEQ_MAXF_OFS, 32'h0000_0000);
    check("maxf reset", rd, 32'h0000_1388);
    bus(1'b1, 8'h20, 32'h0000_FFFF);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    bus(1'b1, `SEQ_SECT_BASE, 32'hFFFF_F830);
    bus(1'b0, `SEQ_SECT_BASE, 32'h0000_0000);
    check("clamp low", rd, 32'hFFFF_FC18);
    bus(1'b1, `SEQ_SECT_BASE, 32'h0000_05DC);
    bus(1'b0, `SEQ_SECT_BASE, 32'h0000_0000);
    check("clamp high", rd, 32'h0000_03E8);
    for (int n = 0; n < 16; n++) begin
      bus(1'b1, `SEQ_SECT_BASE + 8'(8 * n), spd(n));
      bus(1'b1, `SEQ_SECT_BASE + 8'(8 * n + 4), (n == 0) ? 32'h0000_0003 : 32'h0000_0001);
    end
    $display("test settings done");
    run_seq(32'h0000_0000);
    wait_vals(16);
    wait_idle();
    for (int n = 0; n < 16; n++) check("pass step", vals[n], ex(n));
    check("section 0 span", 32'(durs[0] >= 20 && durs[0] <= 32), 32'h0000_0001);
    bus(1'b0, `SEQ_STAT_OFS, 32'h0000_0000);
    check("done flag", rd[2], 32'h0000_0001);
    repeat (40) @(posedge core_clk);
    check("no restart", 32'(vals.size()), 32'h0000_0010);
    $display("test single pass done");
    run_seq(32'h0000_0001);
    wait_vals(16);
    repeat (60) @(negedge core_clk);
    check("hold output", {drive_run, drive_reverse, drive_freq_ref}, {1'b1, ex(15)});
    check("hold steps", 32'(vals.size()), 32'h0000_0010);
    stop_check();
    $display("test hold done");
    run_seq(32'h0000_0002);
    wait_vals(18);
    for (int n = 0; n < 2; n++) check("wrap step", vals[16 + n], ex(n));
    stop_check();
    $display("test cyclic done");
    run_seq(32'h0000_0008);
    wait_vals(2);
    check("minute span", 32'(durs[0] >= 1790 && durs[0] <= 1810), 32'h0000_0001);
    stop_check();
    $display("test minute unit done");
    pf_case(32'h0000_0004, 2);
    pf_case(32'h0000_0000, 0);
    $display("test retention done");
    complete_run();
  end
endmodule
`default_nettype wire
